// ==== core/vectored_interrupt_controller.v ====
// Purpose: Vectored interrupt controller with pending, mask and in-service tracking
// Assumes: Avalon-MM slave on clk_in; request pins are asynchronous, active low
// Notes:   reset_n_in is the total system reset; soft_reset_in is a lesser reset
`timescale 1ns/1ns
`include "vic_map.vh"

module vectored_interrupt_controller (
    input wire clk_in,
    input wire reset_n_in,
    input wire soft_reset_in,
    input wire [`VIC_ADDR_W-1:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    input wire [2:0] request_lines_n_in,
    input wire [15:1] internal_request_source_in,
    output reg [2:0] interrupt_level_out,
    input wire interrupt_acknowledge_cycle_in,
    input wire [2:0] acknowledge_level_in,
    output reg [7:0] vector_out,
    output reg vector_valid_out,
    output reg external_vector_out
);

// ----------------------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------------------
function [15:0] merge16;
    input [15:0] old_value;
    input [31:0] wdata;
    input [3:0] be;
    begin
        merge16 = old_value;
        if (be[0])
            merge16[7:0] = wdata[7:0];
        if (be[1])
            merge16[15:8] = wdata[15:8];
    end
endfunction

function [15:0] lane_bits;
    input [31:0] wdata;
    input [3:0] be;
    begin
        lane_bits = {wdata[15:8] & {8{be[1]}}, wdata[7:0] & {8{be[0]}}};
    end
endfunction

// ----------------------------------------------------------------------------
// State
// ----------------------------------------------------------------------------
reg [15:0] mode_reg;
reg upper_written_reg;
reg [15:0] pend_reg;
reg [15:0] pend_next;
reg [15:0] mask_reg;
reg [15:0] insv_reg;
reg [15:0] insv_next;
reg [2:0] pin_pend_reg;
wire [2:0] pin_pend_next;
reg [2:0] pin_prev_reg;
wire [2:0] pin_sync;

wire line_arrangement_select = mode_reg[`VIC_LINE_ARR_BIT];
wire [2:0] vector_source_sel = mode_reg[`VIC_VSRC_HI:`VIC_VSRC_LO];
wire [2:0] trigger_select = mode_reg[`VIC_TRIG_HI:`VIC_TRIG_LO];
wire [2:0] upper_vector_bits = mode_reg[`VIC_UPPER_HI:`VIC_UPPER_LO];

wire bus_req = avs_read_in | avs_write_in;
wire wr_take = avs_write_in & ~avs_waitrequest_out;

// Pins are asynchronous, so nothing reads them before two flops
vic_sync #(
    .WIDTH(3),
    .RESET_VALUE(3'h7)
) u_pin_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .async_in(request_lines_n_in),
    .sync_out(pin_sync)
);

// ----------------------------------------------------------------------------
// Priority and nesting
// ----------------------------------------------------------------------------
wire insv_found;
wire [3:0] insv_top;
wire [15:0] above_insv = insv_found ? ~((16'h0002 << insv_top) - 16'h0001) : 16'hffff;
wire [15:0] eligible = pend_reg & mask_reg & `VIC_SRC_MASK & above_insv;
wire src_found;
wire [3:0] src_top;

vic_prio #(
    .WIDTH(16),
    .IDX_W(4)
) u_insv_prio (
    .req_in(insv_reg & `VIC_SRC_MASK),
    .found_out(insv_found),
    .index_out(insv_top)
);

vic_prio #(
    .WIDTH(16),
    .IDX_W(4)
) u_src_prio (
    .req_in(eligible),
    .found_out(src_found),
    .index_out(src_top)
);

function [7:0] make_vector;
    input written;
    input [2:0] upper;
    input [4:0] code;
    begin
        if (written)
            make_vector = {upper, code};
        else
            make_vector = `VIC_UNINIT_VECTOR;
    end
endfunction

// ----------------------------------------------------------------------------
// Level presented to the core
// ----------------------------------------------------------------------------
wire [2:0] encoded_priority_lines = ~pin_sync;
reg [2:0] level_next;

always @* begin
    if (line_arrangement_select) begin
        if (pin_pend_reg[2])
            level_next = 3'h7;
        else if (pin_pend_reg[1])
            level_next = 3'h6;
        else if (src_found)
            level_next = `VIC_INTERNAL_LEVEL;
        else if (pin_pend_reg[0])
            level_next = 3'h1;
        else
            level_next = 3'h0;
    end else begin
        if (src_found && encoded_priority_lines < `VIC_INTERNAL_LEVEL)
            level_next = `VIC_INTERNAL_LEVEL;
        else
            level_next = encoded_priority_lines;
    end
end

// ----------------------------------------------------------------------------
// Acknowledge decoding
// ----------------------------------------------------------------------------
wire ack_internal = interrupt_acknowledge_cycle_in &&
    acknowledge_level_in == `VIC_INTERNAL_LEVEL;
reg ack_pin;
reg [1:0] ack_pin_idx;

always @* begin
    ack_pin = 1'b0;
    ack_pin_idx = 2'h0;
    if (interrupt_acknowledge_cycle_in && line_arrangement_select) begin
        case (acknowledge_level_in)
            3'h7: begin
                ack_pin = 1'b1;
                ack_pin_idx = 2'h2;
            end
            3'h6: begin
                ack_pin = 1'b1;
                ack_pin_idx = 2'h1;
            end
            3'h1: begin
                ack_pin = 1'b1;
                ack_pin_idx = 2'h0;
            end
            default: begin
                ack_pin = 1'b0;
                ack_pin_idx = 2'h0;
            end
        endcase
    end
end

// ----------------------------------------------------------------------------
// Dedicated request pins
// ----------------------------------------------------------------------------
genvar k;
generate
    for (k = 0; k < 3; k = k + 1) begin : g_pin
        wire low_now = ~pin_sync[k];
        wire fall = pin_prev_reg[k] & ~pin_sync[k];
        wire acked = ack_pin && ack_pin_idx == k;
        reg bit_next;
        assign pin_pend_next[k] = bit_next;
        always @* begin
            if (!line_arrangement_select)
                bit_next = 1'b0;
            else if (trigger_select[k])
                bit_next = fall | (pin_pend_reg[k] & ~acked);
            else if (k == 2)
                // Level seven re-arms only on a new assertion
                bit_next = fall | (pin_pend_reg[k] & low_now & ~acked);
            else
                bit_next = low_now;
        end
    end
endgenerate

// ----------------------------------------------------------------------------
// Pending and in-service next values
// ----------------------------------------------------------------------------
wire [15:0] insv_set = ack_internal && src_found ? (16'h0001 << src_top) : 16'h0000;
wire err_event = !line_arrangement_select &&
    encoded_priority_lines == `VIC_INTERNAL_LEVEL &&
    (pend_reg & `VIC_SRC_MASK) == 16'h0000;
wire [15:0] src_set = {internal_request_source_in, 1'b0} & `VIC_SRC_MASK;
wire [15:0] wr_clear = lane_bits(avs_writedata_in, avs_byteenable_in);

always @* begin
    pend_next = pend_reg & ~insv_set;
    insv_next = insv_reg;
    if (wr_take && avs_address_in == `VIC_ADDR_PEND)
        pend_next = pend_next & ~wr_clear;
    if (wr_take && avs_address_in == `VIC_ADDR_INSV)
        insv_next = insv_next & ~wr_clear;
    // A new event in the clearing cycle is kept
    pend_next = pend_next | src_set;
    pend_next[`VIC_ERR_BIT] = pend_next[`VIC_ERR_BIT] | err_event;
    insv_next = insv_next | insv_set;
end

// ----------------------------------------------------------------------------
// Sequential state
// ----------------------------------------------------------------------------
always @(posedge clk_in) begin
    if (!reset_n_in) begin
        mode_reg <= `VIC_MODE_RESET;
        upper_written_reg <= 1'b0;
    end else if (wr_take && avs_address_in == `VIC_ADDR_MODE) begin
        mode_reg <= merge16(mode_reg, avs_writedata_in, avs_byteenable_in) &
            `VIC_MODE_WMASK;
        if (avs_byteenable_in[0])
            upper_written_reg <= 1'b1;
    end
end

always @(posedge clk_in) begin
    // The lesser reset leaves the mode register alone
    if (!reset_n_in || soft_reset_in) begin
        pend_reg <= `VIC_PEND_RESET;
        mask_reg <= `VIC_MASK_RESET;
        insv_reg <= `VIC_INSV_RESET;
        pin_pend_reg <= 3'h0;
        pin_prev_reg <= 3'h7;
    end else begin
        pend_reg <= pend_next;
        insv_reg <= insv_next;
        pin_pend_reg <= pin_pend_next;
        pin_prev_reg <= pin_sync;
        if (wr_take && avs_address_in == `VIC_ADDR_MASK)
            mask_reg <= merge16(mask_reg, avs_writedata_in, avs_byteenable_in) &
                `VIC_SRC_MASK;
    end
end

// ----------------------------------------------------------------------------
// Core side outputs
// ----------------------------------------------------------------------------
always @(posedge clk_in) begin
    if (!reset_n_in) begin
        interrupt_level_out <= 3'h0;
        vector_out <= 8'h00;
        vector_valid_out <= 1'b0;
        external_vector_out <= 1'b0;
    end else begin
        interrupt_level_out <= level_next;
        vector_valid_out <= 1'b0;
        external_vector_out <= 1'b0;
        if (ack_internal) begin
            // Always answered here, never left to an outside agent
            vector_valid_out <= 1'b1;
            if (src_found)
                vector_out <= make_vector(upper_written_reg, upper_vector_bits,
                    {1'b0, src_top});
            else
                vector_out <= `VIC_UNINIT_VECTOR;
        end else if (ack_pin && !vector_source_sel[ack_pin_idx]) begin
            vector_valid_out <= 1'b1;
            vector_out <= make_vector(upper_written_reg, upper_vector_bits,
                `VIC_PIN_CODE_BASE | {3'h0, ack_pin_idx});
        end else if (interrupt_acknowledge_cycle_in) begin
            external_vector_out <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------------------
// Avalon slave: one wait cycle, answer on the second cycle
// ----------------------------------------------------------------------------
always @(posedge clk_in) begin
    if (!reset_n_in) begin
        avs_waitrequest_out <= 1'b1;
        avs_readdata_out <= 32'h00000000;
    end else begin
        avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
        if (avs_read_in && avs_waitrequest_out) begin
            case (avs_address_in)
                `VIC_ADDR_MODE: avs_readdata_out <= {16'h0000, mode_reg};
                `VIC_ADDR_PEND: avs_readdata_out <= {16'h0000, pend_reg};
                `VIC_ADDR_MASK: avs_readdata_out <= {16'h0000, mask_reg};
                `VIC_ADDR_INSV: avs_readdata_out <= {16'h0000, insv_reg};
                default: avs_readdata_out <= 32'h00000000;
            endcase
        end
    end
end

endmodule // vectored_interrupt_controller

// ==== core/vic_map.vh ====
// Purpose: Register map, field positions and reset values of the interrupt controller
// Assumes: Avalon-MM word addressing, 16-bit registers in the low half of a 32-bit word
// Notes:   Definitions only
`ifndef VIC_MAP_VH
`define VIC_MAP_VH

// ----------------------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------------------
`define VIC_ADDR_W 3
`define VIC_ADDR_MODE 3'h0
`define VIC_ADDR_PEND 3'h1
`define VIC_ADDR_MASK 3'h2
`define VIC_ADDR_INSV 3'h3

// ----------------------------------------------------------------------------
// Global mode register fields
// ----------------------------------------------------------------------------
`define VIC_MODE_RESET 16'h0000
`define VIC_MODE_WMASK 16'hf7e0
`define VIC_LINE_ARR_BIT 15
`define VIC_VSRC_HI 14
`define VIC_VSRC_LO 12
`define VIC_TRIG_HI 10
`define VIC_TRIG_LO 8
`define VIC_UPPER_HI 7
`define VIC_UPPER_LO 5

// ----------------------------------------------------------------------------
// Pending / mask / in-service layout
// ----------------------------------------------------------------------------
`define VIC_SRC_MASK 16'hfefe
`define VIC_ERR_BIT 0
`define VIC_PEND_RESET 16'h0000
`define VIC_MASK_RESET 16'h0000
`define VIC_INSV_RESET 16'h0000

// ----------------------------------------------------------------------------
// Vectors and levels
// ----------------------------------------------------------------------------
`define VIC_UNINIT_VECTOR 8'h0f
`define VIC_PIN_CODE_BASE 5'h10
`define VIC_INTERNAL_LEVEL 3'h4

`endif

// ==== core/vic_prio.v ====
// Purpose: Fixed priority finder, highest set bit wins
// Assumes: Purely combinational
// Notes:   Index is zero when nothing is set
`timescale 1ns/1ns

module vic_prio #(
    parameter WIDTH = 16,
    parameter IDX_W = 4
) (
    input wire [WIDTH-1:0] req_in,
    output reg found_out,
    output reg [IDX_W-1:0] index_out
);

integer i;

always @* begin
    found_out = 1'b0;
    index_out = {IDX_W{1'b0}};
    for (i = 0; i < WIDTH; i = i + 1) begin
        if (req_in[i]) begin
            found_out = 1'b1;
            index_out = i[IDX_W-1:0];
        end
    end
end

endmodule // vic_prio

// ==== core/vic_sync.v ====
// Purpose: Two-stage synchroniser for a group of asynchronous pins
// Assumes: Single clock, synchronous active-low reset
// Notes:   Stage one feeds stage two only
`timescale 1ns/1ns

module vic_sync #(
    parameter WIDTH = 3,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b1}}
) (
    input wire clk_in,
    input wire reset_n_in,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] stage_reg;

always @(posedge clk_in) begin
    if (!reset_n_in) begin
        stage_reg <= RESET_VALUE;
        sync_out <= RESET_VALUE;
    end else begin
        stage_reg <= async_in;
        sync_out <= stage_reg;
    end
end

endmodule // vic_sync

// ==== sim/vectored_interrupt_controller_bench.sv ====
// Purpose: Self-checking bench for the interrupt controller
// Assumes: Bus master and core model act only just after rising edges
// Notes:   Pin levels are given six edges to pass the synchroniser
`timescale 1ns/1ns
`include "vic_map.vh"

module vectored_interrupt_controller_bench;
    reg clk_in, reset_n_in, soft_reset_in, avs_read_in, avs_write_in;
    reg [2:0] avs_address_in, request_lines_n_in;
    reg [31:0] avs_writedata_in, rdata;
    reg [3:0] avs_byteenable_in;
    reg [15:1] internal_request_source_in;
    wire [31:0] avs_readdata_out;
    wire avs_waitrequest_out, interrupt_acknowledge_cycle_in;
    wire vector_valid_out, external_vector_out;
    wire [2:0] interrupt_level_out, acknowledge_level_in;
    wire [7:0] vector_out;
    reg [7:0] v;
    reg e;
    int fail_count, num_checks, cycles;

    vectored_interrupt_controller DUT (.clk_in, .reset_n_in, .soft_reset_in, .avs_address_in,
        .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
        .avs_waitrequest_out, .request_lines_n_in, .internal_request_source_in,
        .interrupt_level_out, .interrupt_acknowledge_cycle_in, .acknowledge_level_in,
        .vector_out, .vector_valid_out, .external_vector_out);
    vic_core_model core (.clk_in, .vector_valid_in(vector_valid_out),
        .external_vector_in(external_vector_out), .vector_in(vector_out),
        .ack_out(interrupt_acknowledge_cycle_in), .ack_level_out(acknowledge_level_in));

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    // ----
    // Shared tasks
    // ----
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", num_checks, fail_count);
            if (fail_count == 0 && num_checks > 0) begin
                $display("Regression OK");
            end else begin
                $display("Regression broken");
            end
            $finish;
        end
    endtask
    // A hang in any handshake loop ends here
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fail_count++;
            stop_test;
        end
    end
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        begin
            num_checks++;
            if (got !== exp) begin
                fail_count++;
                $display("unexpected %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task bus(input w, input [2:0] a, input [15:0] d);
        begin
            @(posedge clk_in);
            avs_read_in <= !w;
            avs_write_in <= w;
            avs_address_in <= a;
            avs_writedata_in <= {16'h0000, d};
            @(posedge clk_in);
            while (avs_waitrequest_out !== 1'b0) @(posedge clk_in);
            rdata = avs_readdata_out;
            avs_read_in <= 1'b0;
            avs_write_in <= 1'b0;
        end
    endtask
    task rdchk(input [2:0] a, input [15:0] exp, input string what);
        begin
            bus(1'b0, a, 16'h0000);
            chk(what, {16'h0000, exp}, rdata);
        end
    endtask
    task pulse(input [15:0] m);
        begin
            @(posedge clk_in);
            internal_request_source_in <= m[15:1];
            @(posedge clk_in);
            internal_request_source_in <= 15'h0000;
        end
    endtask
    task lvl_chk(input string what, input [2:0] l);
        begin
            repeat (6) @(posedge clk_in);
            chk(what, l, interrupt_level_out);
        end
    endtask
    task ackchk(input string what, input [2:0] l, input [7:0] exp);
        begin
            core.ack_cycle(l, v, e);
            chk(what, {1'b0, exp}, {e, v});
        end
    endtask

    // ----
    // Scenarios
    // ----
    task t_regs;
        begin
            rdchk(`VIC_ADDR_MODE, `VIC_MODE_RESET, "mode");
            rdchk(`VIC_ADDR_PEND, 16'h0000, "pending");
            rdchk(`VIC_ADDR_INSV, 16'h0000, "in_service");
            bus(1'b1, 3'h5, 16'hffff);
            rdchk(3'h5, 16'h0000, "unmapped");
            bus(1'b1, `VIC_ADDR_MASK, 16'hffff);
            rdchk(`VIC_ADDR_MASK, `VIC_SRC_MASK, "mask_rw");
        end
    endtask
    task t_uninit;
        begin
            pulse(16'h8000);
            lvl_chk("level_int", 3'h4);
            ackchk("vec_uninit", 3'h4, `VIC_UNINIT_VECTOR);
            rdchk(`VIC_ADDR_INSV, 16'h8000, "insv_set");
            bus(1'b1, `VIC_ADDR_INSV, 16'h8000);
            rdchk(`VIC_ADDR_INSV, 16'h0000, "insv_clear");
        end
    endtask
    task t_nest;
        begin
            bus(1'b1, `VIC_ADDR_MODE, 16'h8060);
            pulse(16'h1008);
            rdchk(`VIC_ADDR_PEND, 16'h1008, "pend_map");
            ackchk("vec_prio", 3'h4, 8'h6c);
            lvl_chk("level_block", 3'h0);
            pulse(16'h4000);
            lvl_chk("level_nest", 3'h4);
            ackchk("vec_nest", 3'h4, 8'h6e);
            bus(1'b1, `VIC_ADDR_INSV, 16'h5000);
            ackchk("vec_low", 3'h4, 8'h63);
            bus(1'b1, `VIC_ADDR_INSV, 16'h0008);
            bus(1'b1, `VIC_ADDR_MASK, 16'h0000);
            pulse(16'h0200);
            lvl_chk("level_masked", 3'h0);
            bus(1'b1, `VIC_ADDR_MASK, 16'hfefe);
            ackchk("vec_unmasked", 3'h4, 8'h69);
            bus(1'b1, `VIC_ADDR_INSV, 16'h0200);
        end
    endtask
    task t_pins;
        begin
            request_lines_n_in <= 3'b110;
            lvl_chk("level_one", 3'h1);
            ackchk("vec_pin1", 3'h1, 8'h70);
            request_lines_n_in <= 3'b111;
            bus(1'b1, `VIC_ADDR_MODE, 16'h8260);
            request_lines_n_in <= 3'b101;
            lvl_chk("level_six", 3'h6);
            request_lines_n_in <= 3'b111;
            lvl_chk("level_six_held", 3'h6);
            ackchk("vec_pin6", 3'h6, 8'h71);
            request_lines_n_in <= 3'b011;
            lvl_chk("level_seven", 3'h7);
            ackchk("vec_pin7", 3'h7, 8'h72);
            lvl_chk("level_seven_once", 3'h0);
            request_lines_n_in <= 3'b111;
            bus(1'b1, `VIC_ADDR_MODE, 16'hc060);
            request_lines_n_in <= 3'b011;
            lvl_chk("level_seven_ext", 3'h7);
            core.ack_cycle(3'h7, v, e);
            chk("ext_pin7", 1'b1, e);
            request_lines_n_in <= 3'b111;
        end
    endtask
    task t_normal;
        begin
            bus(1'b1, `VIC_ADDR_MODE, 16'h0060);
            request_lines_n_in <= 3'b011;
            repeat (6) @(posedge clk_in);
            rdchk(`VIC_ADDR_PEND, 16'h0001, "pend_err");
            request_lines_n_in <= 3'b111;
            core.ack_cycle(3'h2, v, e);
            chk("ext_vector", 1'b1, e);
            repeat (6) @(posedge clk_in);
            bus(1'b1, `VIC_ADDR_PEND, 16'h0001);
            rdchk(`VIC_ADDR_PEND, 16'h0000, "pend_err_clear");
        end
    endtask
    task t_resets;
        begin
            @(posedge clk_in);
            soft_reset_in <= 1'b1;
            @(posedge clk_in);
            soft_reset_in <= 1'b0;
            rdchk(`VIC_ADDR_MODE, 16'h0060, "mode_soft");
            rdchk(`VIC_ADDR_MASK, 16'h0000, "mask_soft");
            reset_n_in <= 1'b0;
            repeat (3) @(posedge clk_in);
            reset_n_in <= 1'b1;
            rdchk(`VIC_ADDR_MODE, 16'h0000, "mode_total");
        end
    endtask

    initial begin
        reset_n_in = 1'b0;
        soft_reset_in = 1'b0;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_address_in = 3'h0;
        avs_writedata_in = 32'h0;
        avs_byteenable_in = 4'h3;
        request_lines_n_in = 3'h7;
        internal_request_source_in = 15'h0000;
        fail_count = 0;
        num_checks = 0;
        cycles = 0;
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        t_regs;
        t_uninit;
        t_nest;
        t_pins;
        t_normal;
        t_resets;
        stop_test;
    end
endmodule // vectored_interrupt_controller_bench

// ==== sim/vectored_interrupt_controller_checker.sv ====
// Purpose: Port-level assertions for the interrupt controller
// Assumes: One clock, synchronous active-low total reset
// Notes:   Mode register is shadowed from completed bus writes
`timescale 1ns/1ns
`include "vic_map.vh"

module vectored_interrupt_controller_checker (
    input wire clk_in,
    input wire reset_n_in,
    input wire [2:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    input wire [31:0] avs_readdata_out,
    input wire avs_waitrequest_out,
    input wire interrupt_acknowledge_cycle_in,
    input wire [2:0] acknowledge_level_in,
    input wire [7:0] vector_out,
    input wire vector_valid_out,
    input wire external_vector_out
);
    reg [15:0] mode_reg;
    reg upper_reg;
    wire mode_wr = avs_write_in && !avs_waitrequest_out && avs_address_in == `VIC_ADDR_MODE;

    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            mode_reg <= 16'h0000;
            upper_reg <= 1'b0;
        end else if (mode_wr) begin
            if (avs_byteenable_in[0]) begin
                mode_reg[7:0] <= avs_writedata_in[7:0];
                upper_reg <= 1'b1;
            end
            if (avs_byteenable_in[1]) begin
                mode_reg[15:8] <= avs_writedata_in[15:8];
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    // ----
    // Bus and acknowledge timing
    // ----
    sequence bus_req;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence ack_four;
        interrupt_acknowledge_cycle_in && acknowledge_level_in == `VIC_INTERNAL_LEVEL;
    endsequence

    a_wait_one: assert property (bus_req |=> !avs_waitrequest_out) else $error("no answer");
    a_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("wait low twice");
    a_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out && avs_address_in[2]
        |-> avs_readdata_out == 32'h0) else $error("unmapped data");
    a_ack_answer: assert property (interrupt_acknowledge_cycle_in
        |=> vector_valid_out != external_vector_out) else $error("ack answer");
    a_no_stray: assert property (!interrupt_acknowledge_cycle_in
        |=> !vector_valid_out && !external_vector_out) else $error("stray answer");
    a_vector_hold: assert property (!vector_valid_out && !external_vector_out
        |-> $stable(vector_out)) else $error("vector moved");
    a_fixed_vector: assert property (ack_four ##0 !upper_reg
        |=> vector_valid_out && vector_out == `VIC_UNINIT_VECTOR)
        else $error("fixed vector");
    a_upper_vector: assert property (ack_four ##0 upper_reg |=> vector_valid_out
        && (vector_out == `VIC_UNINIT_VECTOR || vector_out[7:4] == {mode_reg[7:5], 1'b0}))
        else $error("upper bits");
    a_normal_external: assert property (interrupt_acknowledge_cycle_in && !mode_reg[15]
        && acknowledge_level_in != 3'h4 |=> external_vector_out) else $error("encoded ack");
    a_ext_seven: assert property (interrupt_acknowledge_cycle_in && mode_reg[15]
        && mode_reg[14] && acknowledge_level_in == 3'h7 |=> external_vector_out)
        else $error("level seven external");
endmodule // vectored_interrupt_controller_checker

bind vectored_interrupt_controller vectored_interrupt_controller_checker u_chk (
    .clk_in, .reset_n_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .interrupt_acknowledge_cycle_in,
    .acknowledge_level_in, .vector_out, .vector_valid_out, .external_vector_out);

// ==== sim/vic_core_model.sv ====
// Purpose: Core side of the interrupt acknowledge cycle
// Assumes: Controller answers one edge after the acknowledge strobe
// Notes:   The bench calls ack_cycle through the instance name
`timescale 1ns/1ns

module vic_core_model (
    input wire clk_in,
    input wire vector_valid_in,
    input wire external_vector_in,
    input wire [7:0] vector_in,
    output reg ack_out,
    output reg [2:0] ack_level_out
);
    initial begin
        ack_out = 1'b0;
        ack_level_out = 3'h0;
    end

    // Strobe lasts one edge; the level is held so a late look never sees a stale code
    task ack_cycle(input [2:0] lvl, output [7:0] vec, output ext);
        begin
            @(posedge clk_in);
            ack_out <= 1'b1;
            ack_level_out <= lvl;
            @(posedge clk_in);
            ack_out <= 1'b0;
            @(posedge clk_in);
            while (!(vector_valid_in || external_vector_in)) @(posedge clk_in);
            vec = vector_in;
            ext = external_vector_in;
        end
    endtask
endmodule // vic_core_model
